/* logic/rtc_interrupt_output_logic.sv */
/*
 * Interrupt output logic of a real time clock: event flags, enables,
 * level or pulse drive of one interrupt pin, square wave and
 * calibration tone override. Assumes event inputs are one-cycle
 * pulses on the core clock and the backup indication comes from
 * another domain.
 */
// What this block does
// - Pin asserts only for flagged enabled source
// - Three sources, enables at 0x06, flags 0x00
// - Pulse mode drives pin about 200 ms
// - Level mode holds pin until flags read
// - No interrupts while on backup supply
// - Watchdog enable gates timeout onto pin
// - Alarm enable gates match onto pin
// - Power fail enable gates detection onto pin
// - Square wave enable overrides interrupts
// - Calibration test outputs 512 Hz, priority over all but backup
// - Polarity bit picks push-pull high or open-drain low
// - Rate bits select 1, 512, 4096, 32768 Hz
// - Flag read clears source flags, ends level drive
// - Flag read ends pulse early
// - Flags load zero at power-up, oscillator included
`timescale 1ns/10ps
`include "rtc_irq_consts.svh"

module rtc_interrupt_output_logic
    import rtc_irq_pkg::*;
#(
    parameter int CNT_W        = 26,
    parameter int PULSE_CYCLES = `PULSE_CYCLES,
    parameter int HALF_1       = `HALF_CYC(`SQW_HZ_1),
    parameter int HALF_512     = `HALF_CYC(`SQW_HZ_512),
    parameter int HALF_4096    = `HALF_CYC(`SQW_HZ_4096),
    parameter int HALF_32768   = `HALF_CYC(`SQW_HZ_32768)
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_wdog_timeout,
    input  wire logic       i_alarm_match,
    input  wire logic       i_power_fail,
    input  wire logic       i_osc_stopped,
    input  wire logic       i_backup_failed,
    input  wire logic       i_on_backup,
    output logic            o_int_out,
    output logic            o_int_oe
);

    logic [7:0]   event_flags;
    logic [2:0]   src_flags;
    logic [1:0]   mon_flags;
    logic [2:0]   ctl_bits;
    logic [7:0]   irq_pin_control;
    logic [1:0]   bk_sync;
    logic         on_backup;
    logic         flag_rd;
    logic         flag_wr;
    logic         ctrl_wr;
    logic [2:0]   src_events;
    logic [2:0]   src_enables;
    logic         irq_pending;
    logic         irq_pending_q;
    logic         pulse_start;
    logic         pulse_done;
    pulse_state_t pulse_state;
    pulse_state_t next_pulse_state;
    logic [CNT_W-1:0] pulse_cnt;
    logic         irq_active;
    pin_src_t     pin_src;
    pin_src_t     next_pin_src;
    logic [CNT_W-1:0] sqw_half;
    logic         wave;
    logic [1:0]   next_drive;

    // Pin level and enable for an asserted or deasserted source
    function automatic logic [1:0] drive_of(input logic act,
                                            input logic high);
        // {out, oe}
        if (high)
            drive_of = {act, 1'b1};
        else
            drive_of = {1'b0, act};
    endfunction

    // Backup indication is asynchronous to the core clock
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            bk_sync <= 2'b00;
        else
            bk_sync <= {bk_sync[0], i_on_backup};
    end
    assign on_backup = bk_sync[1];

    assign flag_rd = i_reg_rd && (i_reg_addr == `OFS_EVENT_FLAGS);
    assign flag_wr = i_reg_wr && (i_reg_addr == `OFS_EVENT_FLAGS);
    assign ctrl_wr = i_reg_wr && (i_reg_addr == `OFS_IRQ_PIN_CONTROL);

    assign src_events  = {i_wdog_timeout, i_alarm_match, i_power_fail};
    assign src_enables = irq_pin_control[`BIT_WDOG_IE:`BIT_PFAIL_IE];
    assign event_flags = {src_flags, mon_flags, ctl_bits};

    // Source flags: set wins over the clearing read
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            src_flags <= 3'(`RST_EVENT_FLAGS >> 5);
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (src_events[i])
                    src_flags[i] <= 1'b1;
                else if (flag_rd)
                    src_flags[i] <= 1'b0;
            end
        end
    end

    // Oscillator and backup status follow their own monitors
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mon_flags <= 2'b00;
        end else begin
            mon_flags <= {i_osc_stopped, i_backup_failed};
        end
    end

    // Test tone bit is guarded by the write enable bit
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctl_bits <= 3'(`RST_EVENT_FLAGS & 8'h07);
        end else if (flag_wr) begin
            if (ctl_bits[`BIT_WRITE_EN])
                ctl_bits[`BIT_CAL_TEST] <= i_reg_wdata[`BIT_CAL_TEST];
            ctl_bits[`BIT_WRITE_EN]   <= i_reg_wdata[`BIT_WRITE_EN];
            ctl_bits[`BIT_READ_LATCH] <= i_reg_wdata[`BIT_READ_LATCH];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            irq_pin_control <= `RST_IRQ_PIN_CONTROL;
        else if (ctrl_wr)
            irq_pin_control <= i_reg_wdata;
    end

    // Read data shows the flags before the read clears them
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_reg_rdata <= 8'h00;
        else if (flag_rd)
            o_reg_rdata <= event_flags;
        else if (i_reg_rd && i_reg_addr == `OFS_IRQ_PIN_CONTROL)
            o_reg_rdata <= irq_pin_control;
        else if (i_reg_rd)
            o_reg_rdata <= 8'h00;
    end

    // Only flagged and enabled sources count, never on backup
    assign irq_pending = |(event_flags[7:5] & src_enables)
                         && !on_backup;

    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            irq_pending_q <= 1'b0;
        else
            irq_pending_q <= irq_pending;
    end

    assign pulse_start = irq_pending && !irq_pending_q
                         && irq_pin_control[`BIT_PULSE_LVL];
    assign pulse_done  = pulse_cnt >= CNT_W'(PULSE_CYCLES - 1);

    always_comb begin
        next_pulse_state = pulse_state;
        unique case (pulse_state)
            PULSE_IDLE: begin
                if (pulse_start && !flag_rd)
                    next_pulse_state = PULSE_BUSY;
            end
            PULSE_BUSY: begin
                if (flag_rd || pulse_done || on_backup)
                    next_pulse_state = PULSE_IDLE;
            end
            default: next_pulse_state = PULSE_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            pulse_state <= PULSE_IDLE;
        else
            pulse_state <= next_pulse_state;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || pulse_state != PULSE_BUSY
            || next_pulse_state != PULSE_BUSY)
            pulse_cnt <= '0;
        else
            pulse_cnt <= pulse_cnt + 1'b1;
    end

    // Level mode follows the pending state until the flag read
    assign irq_active = irq_pin_control[`BIT_PULSE_LVL]
                        ? (pulse_state == PULSE_BUSY)
                        : irq_pending;

    always_comb begin
        unique case (irq_pin_control[`BIT_RATE_HI:`BIT_RATE_LO])
            2'b00: sqw_half = CNT_W'(HALF_1);
            2'b01: sqw_half = CNT_W'(HALF_512);
            2'b10: sqw_half = CNT_W'(HALF_4096);
            2'b11: sqw_half = CNT_W'(HALF_32768);
        endcase
        if (event_flags[`BIT_CAL_TEST])
            sqw_half = CNT_W'(HALF_512);
    end

    square_wave_gen #(
        .CNT_W (CNT_W)
    ) u_wave (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_run      (next_pin_src == PIN_SQW || next_pin_src == PIN_CAL),
        .i_half     (sqw_half),
        .o_wave     (wave)
    );

    // Source priority: backup release, test tone, square wave, interrupts, released
    always_comb begin
        if (on_backup)
            next_pin_src = PIN_OFF;
        else if (event_flags[`BIT_CAL_TEST])
            next_pin_src = PIN_CAL;
        else if (irq_pin_control[`BIT_SQW_EN])
            next_pin_src = PIN_SQW;
        else if (|src_enables)
            next_pin_src = PIN_IRQ;
        else
            next_pin_src = PIN_OFF;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            pin_src <= PIN_OFF;
        else
            pin_src <= next_pin_src;
    end

    always_comb begin
        unique case (pin_src)
            PIN_CAL, PIN_SQW:
                next_drive = drive_of(wave,
                                      irq_pin_control[`BIT_HIGH_LOW]);
            PIN_IRQ:
                next_drive = drive_of(irq_active,
                                      irq_pin_control[`BIT_HIGH_LOW]);
            default:
                next_drive = 2'b00;
        endcase
    end

    // Push-pull drive needs main power, so backup releases the pin
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_int_out <= 1'b0;
            o_int_oe  <= 1'b0;
        end else begin
            o_int_out <= next_drive[1] && !on_backup;
            o_int_oe  <= next_drive[0] && !on_backup;
        end
    end

    flag_set_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_wdog_timeout |=> event_flags[`BIT_WDOG_FLAG])
        else $error("watchdog flag not set");
    pulse_bound_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        pulse_state == PULSE_BUSY && pulse_done && !flag_rd
        |=> pulse_state == PULSE_IDLE && pulse_cnt == '0)
        else $error("pulse outlived its length");
    // First synchroniser stage tells whether backup arrives next cycle
    level_hold_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !irq_pin_control[`BIT_PULSE_LVL] && irq_pending && !flag_rd
        && !ctrl_wr && !bk_sync[0] |=> irq_active)
        else $error("level interrupt dropped without read");
    backup_quiet_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        on_backup ##1 on_backup |-> !o_int_oe && !irq_pending)
        else $error("pin driven on backup supply");
    enable_gate_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        pin_src == PIN_IRQ && pulse_state != PULSE_BUSY && !ctrl_wr
        && (event_flags[7:5] & src_enables) == 3'b000
        |=> !(o_int_oe && o_int_out == irq_pin_control[`BIT_HIGH_LOW]))
        else $error("interrupt without enabled flag");
    read_clear_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        flag_rd && src_events == 3'b000 |=> event_flags[7:5] == 3'b000)
        else $error("flag read did not clear flags");
    pulse_abort_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        pulse_state == PULSE_BUSY && flag_rd |=> pulse_state == PULSE_IDLE)
        else $error("flag read did not end pulse");
    cal_first_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        event_flags[`BIT_CAL_TEST] && !on_backup |=> pin_src == PIN_CAL)
        else $error("test tone lost priority");
    released_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (!event_flags[`BIT_CAL_TEST] && !irq_pin_control[`BIT_SQW_EN]
         && src_enables == 3'b000)[*3] |-> !o_int_oe)
        else $error("pin driven with nothing enabled");
    reset_flags_a: assert property (
        @(posedge i_core_clk)
        i_rst |=> event_flags[7:5] == 3'b000)
        else $error("flags not cleared by reset");

    pulse_full_c: cover property (
        @(posedge i_core_clk) disable iff (i_rst)
        pulse_state == PULSE_BUSY && pulse_done);
    pulse_cut_c: cover property (
        @(posedge i_core_clk) disable iff (i_rst)
        pulse_state == PULSE_BUSY && flag_rd);
    square_c: cover property (
        @(posedge i_core_clk) disable iff (i_rst)
        pin_src == PIN_SQW && $rose(wave));
    level_c: cover property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(irq_pending) && !irq_pin_control[`BIT_PULSE_LVL]);

endmodule

/* include/rtc_irq_consts.svh */
/*
 * Register offsets, bit positions, reset values and timing figures
 * for the interrupt output logic. Assumes a 100 MHz core clock.
 */
`ifndef RTC_IRQ_CONSTS_SVH
`define RTC_IRQ_CONSTS_SVH

`define OFS_EVENT_FLAGS     8'h00
`define OFS_IRQ_PIN_CONTROL 8'h06

// event_flags bit positions
`define BIT_WDOG_FLAG   7
`define BIT_ALARM_FLAG  6
`define BIT_PFAIL_FLAG  5
`define BIT_OSC_STOP    4
`define BIT_BKUP_FAIL   3
`define BIT_CAL_TEST    2
`define BIT_WRITE_EN    1
`define BIT_READ_LATCH  0

// irq_pin_control bit positions
`define BIT_WDOG_IE     7
`define BIT_ALARM_IE    6
`define BIT_PFAIL_IE    5
`define BIT_SQW_EN      4
`define BIT_HIGH_LOW    3
`define BIT_PULSE_LVL   2
`define BIT_RATE_HI     1
`define BIT_RATE_LO     0

`define RST_EVENT_FLAGS     8'h00
`define RST_IRQ_PIN_CONTROL 8'h08

// Timing: figures as printed, cycle counts derived from the clock
`define CORE_CLK_HZ     100000000
`define PULSE_MS        200
`define PULSE_CYCLES    (`PULSE_MS * (`CORE_CLK_HZ / 1000))
`define SQW_HZ_1        1
`define SQW_HZ_512      512
`define SQW_HZ_4096     4096
`define SQW_HZ_32768    32768
`define HALF_CYC(f)     (`CORE_CLK_HZ / (2 * (f)))

`endif

/* include/rtc_irq_pkg.sv */
/*
 * Types shared by the interrupt output logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rtc_irq_pkg;

    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b01,
        PULSE_BUSY = 2'b10
    } pulse_state_t;

    typedef enum logic [3:0] {
        PIN_OFF = 4'b0001,
        PIN_IRQ = 4'b0010,
        PIN_SQW = 4'b0100,
        PIN_CAL = 4'b1000
    } pin_src_t;

endpackage

/* logic/square_wave_gen.sv */
/*
 * Free running square wave from the core clock with a run-time
 * half period. Assumes i_half stays at least 1.
 */
`timescale 1ns/10ps

module square_wave_gen #(
    parameter int CNT_W = 26
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_run,
    input  wire logic [CNT_W-1:0] i_half,
    output logic                  o_wave
);

    logic [CNT_W-1:0] count;

    // Stopped generator restarts from a clean low phase
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_run) begin
            count  <= '0;
            o_wave <= 1'b0;
        end else if (count >= i_half - 1'b1) begin
            count  <= '0;
            o_wave <= ~o_wave;
        end else begin
            count  <= count + 1'b1;
        end
    end

endmodule

/* testbench/irq_host_model.sv */
/* Host side of the interrupt pin: pull resistor and settle blanking.
   Assumes the pin arrives split into level and output enable. */
`timescale 1ns/10ps

module irq_host_model #(
    parameter int SETTLE = 4
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_active_high,
    output logic      o_pin_level,
    output logic      o_irq_active
);
    int settle_cnt;

    // Released pin rests at the inactive level through the resistor
    assign o_pin_level = i_pin_oe ? i_pin_out : ~i_active_high;

    // Pin activity means nothing until the recall has settled
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            settle_cnt <= 0;
        end else if (settle_cnt < SETTLE) begin
            settle_cnt <= settle_cnt + 1;
        end
    end

    assign o_irq_active = (settle_cnt >= SETTLE) &&
                          (o_pin_level === i_active_high);
endmodule

/* testbench/rtc_interrupt_output_logic_tb.sv */
/* Self-checking bench: flag model, pin checks, square wave periods.
   Assumes the shortened counts handed to the instance below. */
`timescale 1ns/10ps
`include "rtc_irq_consts.svh"

module rtc_interrupt_output_logic_tb;
    localparam int PC = 50;
    localparam int H [4] = '{40, 8, 4, 2};
    localparam logic [7:0] FL = `OFS_EVENT_FLAGS;
    localparam logic [7:0] CT = `OFS_IRQ_PIN_CONTROL;

    logic       i_core_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic       i_reg_wr = 1'b0;
    logic       i_reg_rd = 1'b0;
    logic [2:0] ev = 3'h0;
    logic       i_osc_stopped = 1'b0;
    logic       i_backup_failed = 1'b0;
    logic       i_on_backup = 1'b0;
    logic       hi = 1'b1;
    logic [7:0] o_reg_rdata;
    logic       o_int_out;
    logic       o_int_oe;
    logic       irq;
    logic [7:0] r = 8'h14;
    logic [7:0] fl;
    logic [7:0] ex;
    logic [2:0] en;
    int         miscompares = 0;
    int         n_tests = 0;

    always #5 i_core_clk = ~i_core_clk;

    rtc_interrupt_output_logic #(
        .PULSE_CYCLES(PC),
        .HALF_1      (H[0]),
        .HALF_512    (H[1]),
        .HALF_4096   (H[2]),
        .HALF_32768  (H[3])
    ) i_dut (
        .i_core_clk     (i_core_clk),
        .i_rst          (i_rst),
        .i_reg_addr     (i_reg_addr),
        .i_reg_wr       (i_reg_wr),
        .i_reg_rd       (i_reg_rd),
        .i_reg_wdata    (i_reg_wdata),
        .o_reg_rdata    (o_reg_rdata),
        .i_wdog_timeout (ev[2]),
        .i_alarm_match  (ev[1]),
        .i_power_fail   (ev[0]),
        .i_osc_stopped  (i_osc_stopped),
        .i_backup_failed(i_backup_failed),
        .i_on_backup    (i_on_backup),
        .o_int_out      (o_int_out),
        .o_int_oe       (o_int_oe)
    );

    irq_host_model #(.SETTLE(4)) i_host (
        .i_core_clk   (i_core_clk),
        .i_rst        (i_rst),
        .i_pin_out    (o_int_out),
        .i_pin_oe     (o_int_oe),
        .i_active_high(hi),
        .o_pin_level  (),
        .o_irq_active (irq)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic end_of_test();
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] g, e, input string m);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic tmo(input int k, n);
        if (k >= n) begin
            miscompares++;
            $display("mismatch %0t wait ran out", $time);
            end_of_test();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    task automatic wr(input logic [7:0] a, d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        cyc(1);
        i_reg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, e, m, input string s);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        cyc(1);
        i_reg_rd = 1'b0;
        cmp(o_reg_rdata & m, e & m, s);
        cyc(1);
    endtask

    task automatic fire(input logic [2:0] e);
        ev = e;
        cyc(1);
        ev = 3'h0;
        cyc(1);
    endtask

    task automatic wait_pin(input logic want, input int n);
        int k;
        for (k = 0; k < n && irq !== want; k++) cyc(1);
        tmo(k, n);
        cmp({7'h00, irq}, {7'h00, want}, "pin");
    endtask

    // Skips the first, possibly partial, half period after a change
    task automatic half(input int e);
        int k;
        logic p;
        p = o_int_out;
        for (k = 0; k < 200 && o_int_out === p; k++) cyc(1);
        tmo(k, 200);
        p = o_int_out;
        for (k = 0; k < 200 && o_int_out === p; k++) cyc(1);
        tmo(k, 200);
        cmp(8'(k), 8'(e), "half period");
    endtask

    initial begin
        int i;
        int k;
        cyc(3);
        i_rst = 1'b0;
        cyc(4);
        rd(FL, `RST_EVENT_FLAGS, 8'hff, "flags rst");
        rd(CT, `RST_IRQ_PIN_CONTROL, 8'hff, "ctl rst");
        rd(8'h03, 8'h00, 8'hff, "unmapped");
        cmp({7'h00, o_int_oe}, 8'h00, "released");
        for (i = 0; i < 3; i++) begin
            wr(CT, 8'h08);
            fire(3'b100 >> i);
            cyc(4);
            cmp({7'h00, irq}, 8'h00, "disabled");
            rd(FL, 8'h80 >> i, 8'he0, "flag only");
            wr(CT, 8'h08 | (8'h80 >> i));
            fire(3'b100 >> i);
            wait_pin(1'b1, 6);
            cyc(20);
            cmp({7'h00, irq}, 8'h01, "level held");
            rd(FL, 8'h80 >> i, 8'hff, "flag read");
            wait_pin(1'b0, 4);
        end
        hi = 1'b0;
        wr(CT, 8'h40);
        fire(3'b010);
        wait_pin(1'b1, 6);
        cmp({6'h00, o_int_oe, o_int_out}, 8'h02, "open drain");
        rd(FL, 8'h40, 8'he0, "flag low");
        wait_pin(1'b0, 4);
        wr(CT, 8'h08);
        hi = 1'b1;
        wr(CT, 8'h4c);
        fire(3'b010);
        wait_pin(1'b1, 6);
        for (k = 0; k < 200 && irq === 1'b1; k++) cyc(1);
        cmp(8'(k), 8'(PC), "pulse width");
        rd(FL, 8'h40, 8'he0, "flag pulse");
        fire(3'b010);
        wait_pin(1'b1, 6);
        cyc(10);
        rd(FL, 8'h40, 8'he0, "flag early");
        wait_pin(1'b0, 4);
        // Backup must hold the pin released though a flag is pending
        i_on_backup = 1'b1;
        wr(CT, 8'h48);
        cyc(4);
        fire(3'b010);
        for (k = 0; k < 10; k++) begin
            cyc(1);
            cmp({7'h00, o_int_oe}, 8'h00, "backup");
        end
        rd(FL, 8'h40, 8'he0, "backup flag");
        i_on_backup = 1'b0;
        cyc(4);
        for (i = 0; i < 4; i++) begin
            wr(CT, 8'h18 | 8'(i));
            half(H[i]);
        end
        wr(FL, 8'h02);
        wr(FL, 8'h06);
        half(H[1]);
        wr(FL, 8'h02);
        wr(FL, 8'h00);
        wr(CT, 8'h08);
        rd(FL, 8'h00, 8'hff, "flags idle");
        r = lfsr(r);
        i_osc_stopped = r[0];
        i_backup_failed = r[1];
        en = r[7:5];
        wr(CT, {en, 5'h08});
        fl = {3'h0, r[0], r[1], 3'h0};
        for (i = 0; i < 300; i++) begin
            r = lfsr(r);
            ev = r[2:0] & {3{r[7:6] == 2'b00}};
            i_reg_rd = r[5] & r[3];
            i_reg_addr = FL;
            ex = fl;
            fl[7:5] = i_reg_rd ? ev : fl[7:5] | ev;
            cyc(1);
            if (i_reg_rd) cmp(o_reg_rdata, ex, "random read");
        end
        ev = 3'h0;
        i_reg_rd = 1'b0;
        cyc(4);
        cmp({7'h00, irq}, {7'h00, |(fl[7:5] & en)}, "random pin");
        end_of_test();
    end
endmodule
